// ==== core/dvspr_cfg.svh ====
// constants for the preset setpoint ramp control block
`ifndef DVSPR_CFG_SVH
`define DVSPR_CFG_SVH

// register offsets and unmapped read value
`define DVSPR_ADDR_PRESET_A   8'h00
`define DVSPR_ADDR_PRESET_B   8'h01
`define DVSPR_READ_UNMAPPED   8'h00

// preset register layout
`define DVSPR_MODE_BIT        7
`define DVSPR_CODE_MSB        6
`define DVSPR_CODE_LSB        0

// voltage code: 500 mV plus 10 mV per code, up to 1770 mV
`define DVSPR_VOUT_MIN_MV     16'h01F4
`define DVSPR_VOUT_STEP_MV    16'h000A
`define DVSPR_VOUT_MAX_MV     16'h06EA
`define DVSPR_CODE_MIN        7'h00

// reset codes, first variant (1.20 V / 1.16 V)
`define DVSPR_RST_A_VAR0      7'h46
`define DVSPR_RST_B_VAR0      7'h42
// reset codes, second variant (0.96 V / 1.40 V)
`define DVSPR_RST_A_VAR1      7'h2E
`define DVSPR_RST_B_VAR1      7'h5A
// reset mode: power save
`define DVSPR_RST_FORCE_PWM   1'b0

// setpoint step sizes in code units (20 mV and 10 mV)
`define DVSPR_FULL_STEP       7'h02
`define DVSPR_HALF_STEP       7'h01

// timing: clock period 100 ns, one 20 mV step at 32 mV/us is 625 ns
`define DVSPR_CLK_PERIOD_PS   32'h0001_86A0
`define DVSPR_BASE_STEP_PS    32'h0009_8968
`define DVSPR_ACC_ZERO        32'h0000_0000

`endif

// ==== core/dvspr_ctrl.sv ====
// preset setpoint ramp control: two presets, select pin, stepped ramp
// Functional notes
// - select low uses preset A, select high uses preset B.
// - select pin has an optional internal pull-down; otherwise driven externally.
// - presets reset to power save with variant-dependent voltages; host may rewrite.
// - 7-bit voltage code: 500 mV plus 10 mV per step, to 1770 mV.
// - write to the active preset takes effect once the write completes.
// - either preset writable any time; host may toggle select afterwards.
// - bit 7 of each preset picks power save or forced PWM.
// - mode bit change in active preset takes effect immediately.
// - one ramp rate setting governs both presets.
// - slope is 32 mV/us divided by two to the ramp code.
// - setpoint moves in discrete steps paced by the internal oscillator.
// - steps are 20 mV, with a final 10 mV step when needed.
// - forced PWM enforces the slope rising and falling.
// - power save still enforces the rising slope.
// - ramp-down-in-PFM bit enforces falling slope in power save.
// - without that bit, falls in power save are not actively driven.
// - after start-up from minimum voltage, setpoint rises at programmed rate.
`timescale 1ns/1ps
`include "dvspr_cfg.svh"

module dvspr_ctrl #(
   parameter bit VARIANT_B = 1'b0
) (
   // clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       RST_N,
   // preset select pin and its pull-down
   input  wire logic       PRESET_SELECT_PIN,
   input  wire logic       SELECT_PULLDOWN_REQ,
   output logic            SELECT_PULLDOWN_EN,
   // register port, write strobe marks a completed write command
   input  wire logic       REG_WR,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic [7:0]      REG_RDATA,
   // global ramp settings
   input  wire logic [2:0] RAMP_RATE_CODE,
   input  wire logic       RAMP_DOWN_IN_PFM,
   // regulation loop controls
   output logic [6:0]      SETPOINT_CODE,
   output logic            ACTIVE_FORCE_PWM,
   output logic            ACTIVE_PRESET,
   output logic            RAMP_BUSY,
   output logic            FALL_SINK_EN
);

   localparam logic [6:0] RST_CODE_A = VARIANT_B ? `DVSPR_RST_A_VAR1 : `DVSPR_RST_A_VAR0;
   localparam logic [6:0] RST_CODE_B = VARIANT_B ? `DVSPR_RST_B_VAR1 : `DVSPR_RST_B_VAR0;

   logic                          sel_meta_q;
   logic                          sel_sync_q;
   logic                          pulldown_q;
   dvspr_pkg::dvspr_preset_t      preset_q [2];
   dvspr_pkg::dvspr_preset_t      active;
   logic [7:0]                    rdata_q;
   logic [6:0]                    setpoint_q;
   logic [6:0]                    setpoint_d;
   dvspr_pkg::dvspr_ramp_state_t  state_q;
   dvspr_pkg::dvspr_ramp_state_t  state_d;
   logic                          pwm_q;
   logic                          act_sel_q;
   logic                          busy_q;
   logic                          sink_q;
   logic                          up;
   logic                          down;
   logic                          controlled_fall;
   logic [6:0]                    diff;
   logic [6:0]                    step;
   logic                          half;
   logic                          run;
   logic                          tick;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sel_meta_q <= 1'b0;
         sel_sync_q <= 1'b0;
      end else begin
         sel_meta_q <= PRESET_SELECT_PIN;
         sel_sync_q <= sel_meta_q;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pulldown_q <= 1'b0;
      end else begin
         pulldown_q <= SELECT_PULLDOWN_REQ;
      end
   end

   // preset registers
   for (genvar i = 0; i < 2; i++) begin : g_preset
      localparam logic [7:0] ADDR     = (i == 0) ? `DVSPR_ADDR_PRESET_A : `DVSPR_ADDR_PRESET_B;
      localparam logic [6:0] RST_CODE = (i == 0) ? RST_CODE_A : RST_CODE_B;
      always_ff @(posedge REF_CLK) begin
         if (!RST_N) begin
            preset_q[i].force_pwm    <= `DVSPR_RST_FORCE_PWM;
            preset_q[i].voltage_code <= RST_CODE;
         end else if (REG_WR && (REG_ADDR == ADDR)) begin
            preset_q[i].force_pwm    <= REG_WDATA[`DVSPR_MODE_BIT];
            preset_q[i].voltage_code <= REG_WDATA[`DVSPR_CODE_MSB:`DVSPR_CODE_LSB];
         end
      end
   end

   // register read-back, one cycle after the address
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         rdata_q <= `DVSPR_READ_UNMAPPED;
      end else if (REG_ADDR == `DVSPR_ADDR_PRESET_A) begin
         rdata_q <= preset_q[0];
      end else if (REG_ADDR == `DVSPR_ADDR_PRESET_B) begin
         rdata_q <= preset_q[1];
      end else begin
         rdata_q <= `DVSPR_READ_UNMAPPED;
      end
   end

   always_comb begin
      // completed write to active preset seen next cycle
      active          = preset_q[sel_sync_q];
      // target compared in 10 mV code units
      up              = active.voltage_code > setpoint_q;
      down            = active.voltage_code < setpoint_q;
      // ramp-down bit controls falls in power save
      controlled_fall = active.force_pwm || RAMP_DOWN_IN_PFM;
      diff            = up ? (active.voltage_code - setpoint_q) : (setpoint_q - active.voltage_code);
      // 20 mV steps, final 10 mV
      half            = (diff == `DVSPR_HALF_STEP);
      step            = half ? `DVSPR_HALF_STEP : `DVSPR_FULL_STEP;
      run             = up || (down && controlled_fall);
   end

   dvspr_ramp_timer u_timer (
      .clk       (REF_CLK),
      .rst_n     (RST_N),
      .run       (run),
      .half      (half),
      .rate_code (RAMP_RATE_CODE),
      .tick      (tick)
   );

   always_comb begin
      setpoint_d = setpoint_q;
      // each tick steps from present setpoint toward current target
      if (tick && up) begin
         setpoint_d = setpoint_q + step;
      end else if (tick && down) begin
         setpoint_d = setpoint_q - step;
      end else if (down && !controlled_fall) begin
         // uncontrolled fall, setpoint drops at once
         setpoint_d = active.voltage_code;
      end
   end

   always_comb begin
      unique case (state_q)
         dvspr_pkg::DVSPR_IDLE,
         dvspr_pkg::DVSPR_RISE,
         dvspr_pkg::DVSPR_FALL: begin
            if (up) begin
               state_d = dvspr_pkg::DVSPR_RISE;
            end else if (down && controlled_fall) begin
               state_d = dvspr_pkg::DVSPR_FALL;
            end else begin
               state_d = dvspr_pkg::DVSPR_IDLE;
            end
         end
         default: begin
            state_d = dvspr_pkg::DVSPR_IDLE;
         end
      endcase
   end

   // start at minimum code and ramp up after reset
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         setpoint_q <= `DVSPR_CODE_MIN;
      end else begin
         setpoint_q <= setpoint_d;
      end
   end

   // ramp direction state
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_q <= dvspr_pkg::DVSPR_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         pwm_q <= `DVSPR_RST_FORCE_PWM;
      end else begin
         pwm_q <= active.force_pwm;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         act_sel_q <= 1'b0;
      end else begin
         act_sel_q <= sel_sync_q;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != dvspr_pkg::DVSPR_IDLE);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         sink_q <= 1'b0;
      end else begin
         sink_q <= (state_d == dvspr_pkg::DVSPR_FALL);
      end
   end

   assign SELECT_PULLDOWN_EN = pulldown_q;
   assign REG_RDATA          = rdata_q;
   assign SETPOINT_CODE      = setpoint_q;
   assign ACTIVE_FORCE_PWM   = pwm_q;
   assign ACTIVE_PRESET      = act_sel_q;
   assign RAMP_BUSY          = busy_q;
   assign FALL_SINK_EN       = sink_q;

endmodule : dvspr_ctrl

// ==== core/dvspr_pkg.sv ====
// types for the preset setpoint ramp control block
package dvspr_pkg;

   typedef struct packed {
      logic       force_pwm;
      logic [6:0] voltage_code;
   } dvspr_preset_t;

   typedef enum logic [1:0] {
      DVSPR_IDLE = 2'b00,
      DVSPR_RISE = 2'b01,
      DVSPR_FALL = 2'b10
   } dvspr_ramp_state_t;

endpackage : dvspr_pkg

// ==== core/dvspr_ramp_timer.sv ====
// step pacing timer for the setpoint ramp
`timescale 1ns/1ps
`include "dvspr_cfg.svh"

module dvspr_ramp_timer (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // pacing control
   input  wire logic       run,
   input  wire logic       half,
   input  wire logic [2:0] rate_code,
   // step strobe
   output logic            tick
);

   logic [31:0] acc_q;
   logic [31:0] acc_d;
   logic [31:0] period;
   logic [31:0] cost;
   logic [31:0] sum;

   // period doubles per rate code; time carried in ps so the average is exact
   always_comb begin
      period = `DVSPR_BASE_STEP_PS << rate_code;
      cost   = half ? (period >> 1) : period;
      sum    = acc_q + `DVSPR_CLK_PERIOD_PS;
      tick   = run && (sum >= cost);
      if (!run) begin
         acc_d = `DVSPR_ACC_ZERO;
      end else if (tick) begin
         acc_d = sum - cost;
      end else begin
         acc_d = sum;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_q <= `DVSPR_ACC_ZERO;
      end else begin
         acc_q <= acc_d;
      end
   end

endmodule : dvspr_ramp_timer

// ==== dv/dvspr_ctrl_properties.sv ====
// assertion checker for the preset ramp control block
`timescale 1ns/1ps
module dvspr_ctrl_properties (
   // clock and reset
   input wire logic       REF_CLK,
   input wire logic       RST_N,
   // inputs
   input wire logic       PRESET_SELECT_PIN,
   input wire logic       SELECT_PULLDOWN_REQ,
   input wire logic       REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [2:0] RAMP_RATE_CODE,
   input wire logic       RAMP_DOWN_IN_PFM,
   // outputs
   input wire logic       SELECT_PULLDOWN_EN,
   input wire logic [7:0] REG_RDATA,
   input wire logic [6:0] SETPOINT_CODE,
   input wire logic       ACTIVE_FORCE_PWM,
   input wire logic       ACTIVE_PRESET,
   input wire logic       RAMP_BUSY,
   input wire logic       FALL_SINK_EN
);
   logic [2:0] up_q;
   // cycles since reset release, saturating
   always_ff @(posedge REF_CLK) begin
      up_q <= !RST_N ? 3'h0 : (up_q == 3'h7 ? up_q : up_q + 3'h1);
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   a_pulldown_copy: assert property (
      up_q > 3'h1 |-> SELECT_PULLDOWN_EN == $past(SELECT_PULLDOWN_REQ)) else $error("pulldown lag");
   a_preset_follow: assert property (
      up_q > 3'h3 |-> ACTIVE_PRESET == $past(PRESET_SELECT_PIN, 3)) else $error("preset lag");
   a_step_size: assert property (
      RAMP_BUSY && $changed(SETPOINT_CODE) |->
      (SETPOINT_CODE - $past(SETPOINT_CODE)) inside {7'h01, 7'h02, 7'h7E, 7'h7F}) else $error("bad step");
   a_step_spacing: assert property (
      $past(RAMP_BUSY) && $changed(SETPOINT_CODE) ##1 RAMP_BUSY |-> $stable(SETPOINT_CODE))
      else $error("steps too close");
   a_pace_bound: assert property (
      RAMP_BUSY && RAMP_RATE_CODE == 3'h0 |-> ##[1:10] ($changed(SETPOINT_CODE) || !RAMP_BUSY))
      else $error("step late");
   a_sink_cause: assert property (
      $rose(FALL_SINK_EN) |-> ACTIVE_FORCE_PWM || $past(RAMP_DOWN_IN_PFM)) else $error("sink uncalled");
   a_write_readback: assert property (
      REG_WR && REG_ADDR < 8'h02 ##1 !REG_WR && $stable(REG_ADDR) |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("readback wrong");
   a_unmapped_zero: assert property (
      up_q > 3'h1 && $past(REG_ADDR) > 8'h01 |-> REG_RDATA == 8'h00) else $error("unmapped not zero");
endmodule : dvspr_ctrl_properties
bind dvspr_ctrl dvspr_ctrl_properties dvspr_ctrl_properties_i (
   .REF_CLK             (REF_CLK),
   .RST_N               (RST_N),
   .PRESET_SELECT_PIN   (PRESET_SELECT_PIN),
   .SELECT_PULLDOWN_REQ (SELECT_PULLDOWN_REQ),
   .REG_WR              (REG_WR),
   .REG_ADDR            (REG_ADDR),
   .REG_WDATA           (REG_WDATA),
   .RAMP_RATE_CODE      (RAMP_RATE_CODE),
   .RAMP_DOWN_IN_PFM    (RAMP_DOWN_IN_PFM),
   .SELECT_PULLDOWN_EN  (SELECT_PULLDOWN_EN),
   .REG_RDATA           (REG_RDATA),
   .SETPOINT_CODE       (SETPOINT_CODE),
   .ACTIVE_FORCE_PWM    (ACTIVE_FORCE_PWM),
   .ACTIVE_PRESET       (ACTIVE_PRESET),
   .RAMP_BUSY           (RAMP_BUSY),
   .FALL_SINK_EN        (FALL_SINK_EN)
);

// ==== dv/dvspr_ctrl_test.sv ====
// self-checking bench for the preset ramp control block
`timescale 1ns/1ps
module dvspr_ctrl_test;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       pd_req = 1'b1;
   logic [2:0] rate = 3'h0;
   logic       rdpfm = 1'b0;
   logic       wr, sel, pd_en, fpwm, apre, busy, sink;
   logic [7:0] addr, wdata, rdata, d;
   logic [6:0] sp;
   int         err_count = 0;
   int         checked = 0;
   int         cyc = 0;
   int         n;
   always #50 clk = ~clk;
   dvspr_host_model dvspr_host_model_i (.clk(clk), .rdata(rdata), .wr(wr), .addr(addr), .wdata(wdata), .sel(sel));
   dvspr_ctrl dvspr_ctrl_i (.REF_CLK(clk), .RST_N(rst_n), .PRESET_SELECT_PIN(sel), .SELECT_PULLDOWN_REQ(pd_req),
      .SELECT_PULLDOWN_EN(pd_en), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .RAMP_RATE_CODE(rate), .RAMP_DOWN_IN_PFM(rdpfm), .SETPOINT_CODE(sp), .ACTIVE_FORCE_PWM(fpwm),
      .ACTIVE_PRESET(apre), .RAMP_BUSY(busy), .FALL_SINK_EN(sink));
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic settle(logic [6:0] t);
      n = 0;
      while (sp !== t && n < 6000) begin
         @(posedge clk) #1 n++;
      end
   endtask : settle
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         err_count++;
         final_report();
      end
   end
   task automatic t_reset;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      settle(7'h46);
      chk("start target", 8'h46, {1'b0, sp});
      chk("rise paced", 8'h01, {7'h00, n > 210 && n < 240});
      dvspr_host_model_i.rd_reg(8'h00, d);
      chk("preset a reset", 8'h46, d);
      dvspr_host_model_i.rd_reg(8'h01, d);
      chk("preset b reset", 8'h42, d);
      dvspr_host_model_i.rd_reg(8'h07, d);
      chk("unmapped read", 8'h00, d);
      chk("pulldown on", 8'h01, {7'h00, pd_en});
      @(posedge clk);
      pd_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("pulldown off", 8'h00, {7'h00, pd_en});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_select;
      dvspr_host_model_i.wr_reg(8'h01, 8'hC8);
      repeat (4) @(posedge clk);
      #1 chk("inactive write", 8'h46, {1'b0, sp});
      dvspr_host_model_i.rd_reg(8'h01, d);
      chk("preset b readback", 8'hC8, d);
      dvspr_host_model_i.set_sel(1'b1);
      settle(7'h48);
      chk("preset b active", 8'h01, {7'h00, apre});
      chk("preset b mode", 8'h01, {7'h00, fpwm});
      chk("preset b target", 8'h48, {1'b0, sp});
      $display("t_select done");
   endtask : t_select
   task automatic t_fall;
      dvspr_host_model_i.wr_reg(8'h01, 8'hC5);
      n = 0;
      while (sp === 7'h48 && n < 50) begin
         @(posedge clk) #1 n++;
      end
      chk("full step down", 8'h46, {1'b0, sp});
      chk("sink on", 8'h01, {7'h00, sink});
      chk("busy on", 8'h01, {7'h00, busy});
      settle(7'h45);
      chk("half step end", 8'h45, {1'b0, sp});
      $display("t_fall done");
   endtask : t_fall
   task automatic t_psm;
      dvspr_host_model_i.wr_reg(8'h01, 8'h40);
      settle(7'h40);
      chk("fall not paced", 8'h01, {7'h00, n < 5});
      chk("mode in active", 8'h00, {7'h00, fpwm});
      chk("busy off", 8'h00, {7'h00, busy});
      chk("sink off", 8'h00, {7'h00, sink});
      @(posedge clk);
      rdpfm <= 1'b1;
      dvspr_host_model_i.wr_reg(8'h01, 8'h3C);
      settle(7'h3C);
      chk("fall paced", 8'h01, {7'h00, n > 10 && n < 20});
      $display("t_psm done");
   endtask : t_psm
   task automatic t_rate;
      int exp;
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         rate <= c[2:0];
         exp = (625 << c) / 100;
         dvspr_host_model_i.wr_reg(8'h01, c[0] ? 8'hBC : 8'hBE);
         settle(c[0] ? 7'h3C : 7'h3E);
         chk("step time", 8'h01, {7'h00, n >= exp && n <= exp + 5});
      end
      $display("t_rate done");
   endtask : t_rate
   task automatic t_retarget;
      @(posedge clk);
      rate <= 3'h0;
      dvspr_host_model_i.wr_reg(8'h01, 8'hC4);
      n = 0;
      while (sp === 7'h3C && n < 50) begin
         @(posedge clk) #1 n++;
      end
      chk("first rise step", 8'h3E, {1'b0, sp});
      dvspr_host_model_i.wr_reg(8'h01, 8'hB8);
      n = 0;
      while (sp === 7'h3E && n < 50) begin
         @(posedge clk) #1 n++;
      end
      chk("turn from setpoint", 8'h3C, {1'b0, sp});
      settle(7'h38);
      chk("new target", 8'h38, {1'b0, sp});
      $display("t_retarget done");
   endtask : t_retarget
   initial begin
      t_reset();
      t_select();
      t_fall();
      t_psm();
      t_rate();
      t_retarget();
      final_report();
   end
endmodule : dvspr_ctrl_test

// ==== dv/dvspr_host_model.sv ====
// host side model: register writes, reads and preset select pin
`timescale 1ns/1ps
module dvspr_host_model (
   // clock and read data
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   // register port and select pin
   output logic            wr,
   output logic [7:0]      addr,
   output logic [7:0]      wdata,
   output logic            sel
);
   initial begin
      wr = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      sel = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      repeat (2) @(posedge clk);
      #1 d = rdata;
   endtask : rd_reg
   task automatic set_sel(input logic v);
      @(posedge clk);
      sel <= v;
   endtask : set_sel
endmodule : dvspr_host_model
